// *** hhtm_line_meas.sv ***
// line measurement and lock filter for one port
`timescale 1ns/1ps
`default_nettype none
module hhtm_line_meas (
    input wire logic clk,  // system clock
    input wire logic rst,  // async reset, high
    hhtm_meas_if.meas m    // samples and results
);
    import hhtm_pkg::*;
    typedef enum logic {LK_SEARCH, LK_LOCKED} hhtm_lk_t;
    hhtm_lk_t         st_ff;
    logic             ns, ns_q_ff, de_q_ff, ln_end, de_ok, hs_ok, lk;
    logic [CNT_W-1:0] pos_ff, npos, hi_ff, de_on_ff, de_off_ff, ns_off_ff;
    logic [CNT_W-1:0] p_on_ff, p_off_ff, p_ns_ff, p_tot_ff, tot;
    logic [RUN_W-1:0] good_ff, de_bad_ff, hs_bad_ff;
    logic [CNT_W-1:0] d_bp, d_act, d_fp;
    // sync normalised so that it is high during the pulse
    assign ns     = m.pol ? m.hs : ~m.hs;
    assign npos   = pos_ff + 14'h0001;
    assign ln_end = m.tick & ns & ~ns_q_ff;
    assign tot    = npos;
    assign lk     = (st_ff == LK_LOCKED);
    // transition positions equal to the previous line
    assign de_ok  = (de_on_ff == p_on_ff) && (de_off_ff == p_off_ff);
    assign hs_ok  = (ns_off_ff == p_ns_ff) && (tot == p_tot_ff);
    assign d_bp   = de_on_ff - ns_off_ff;
    assign d_act  = de_off_ff - de_on_ff;
    assign d_fp   = tot - de_off_ff;
    // position counter and transition capture per line
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pos_ff    <= '0;
            hi_ff     <= '0;
            ns_q_ff   <= 1'b1; // idle sync level, no false line end
            de_q_ff   <= 1'b0;
            de_on_ff  <= '0;
            de_off_ff <= '0;
            ns_off_ff <= '0;
            p_on_ff   <= '0;
            p_off_ff  <= '0;
            p_ns_ff   <= '0;
            p_tot_ff  <= '0;
        end else if (m.restart) begin
            pos_ff   <= '0;
            hi_ff    <= '0;
            p_tot_ff <= '0;
        end else if (m.tick) begin
            ns_q_ff <= ns;
            de_q_ff <= m.de;
            if (ln_end) begin
                pos_ff   <= '0;
                hi_ff    <= {13'h0000, m.hs};
                p_on_ff  <= de_on_ff;
                p_off_ff <= de_off_ff;
                p_ns_ff  <= ns_off_ff;
                p_tot_ff <= tot;
            end else begin
                pos_ff <= npos;
                hi_ff  <= hi_ff + {13'h0000, m.hs};
                if (m.de && !de_q_ff) de_on_ff <= npos;
                if (!m.de && de_q_ff) de_off_ff <= npos;
                if (!ns && ns_q_ff) ns_off_ff <= npos;
            end
        end
    end
    // run counters of matching and differing lines
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            good_ff   <= '0;
            de_bad_ff <= '0;
            hs_bad_ff <= '0;
        end else if (m.restart) begin
            good_ff   <= '0;
            de_bad_ff <= '0;
            hs_bad_ff <= '0;
        end else if (ln_end) begin
            good_ff   <= (de_ok && hs_ok) ? good_ff + 4'h1 : 4'h0; // [RQ1]
            de_bad_ff <= de_ok ? 4'h0 : de_bad_ff + 4'h1;           // [RQ2]
            hs_bad_ff <= hs_ok ? 4'h0 : hs_bad_ff + 4'h1;           // [RQ2]
            if (good_ff == 4'hF) good_ff <= 4'hF;
            if (de_bad_ff == 4'hF) de_bad_ff <= 4'hF;
            if (hs_bad_ff == 4'hF) hs_bad_ff <= 4'hF;
        end
    end
    // lock state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) st_ff <= LK_SEARCH;
        else if (m.restart) st_ff <= LK_SEARCH;
        else if (ln_end) begin
            case (st_ff)
                LK_SEARCH: if (de_ok && hs_ok &&
                               good_ff >= RUN_W'(LOCK_LINES - 1))
                    st_ff <= LK_LOCKED;                             // [RQ1]
                LK_LOCKED: if ((!de_ok &&
                                de_bad_ff >= RUN_W'(UNLOCK_LINES - 1)) ||
                               (!hs_ok &&
                                hs_bad_ff >= RUN_W'(UNLOCK_LINES - 1)))
                    st_ff <= LK_SEARCH;                             // [RQ2]
                default: st_ff <= LK_SEARCH;
            endcase
        end
    end
    // results, one coherent set per matching locked line, zero until lock; pol set at every line end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            m.total    <= MEAS_RST; // [RQ22]
            m.active   <= '0;
            m.fporch   <= '0;
            m.pulse    <= '0;
            m.bporch   <= '0;
            m.pol      <= 1'b0;
            m.locked   <= 1'b0;
            m.line_end <= 1'b0;
        end else begin
            m.locked   <= lk;
            m.line_end <= ln_end;
            if (ln_end) m.pol <= ({hi_ff[CNT_W-2:0], 1'b0} < tot); // [RQ11]
            if (ln_end && de_ok && hs_ok &&
                (lk || good_ff >= RUN_W'(LOCK_LINES - 1))) begin
                m.total  <= tot;                                    // [RQ5]
                m.active <= d_act[ACT_W-1:0];                       // [RQ6]
                m.fporch <= d_fp[ACT_W-1:0];                        // [RQ7]
                m.pulse  <= ns_off_ff[ACT_W-1:0];                   // [RQ8]
                m.bporch <= d_bp[ACT_W-1:0];                        // [RQ9]
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_lock_entry: assert property ($rose(lk) |-> // [RQ1]
        $past(good_ff) >= RUN_W'(LOCK_LINES - 1))
        else $error("lock taken before eight matching lines");
    chk_unlock_count: assert property ($fell(lk) && !$past(m.restart) |-> // [RQ2]
        ($past(de_bad_ff) >= RUN_W'(UNLOCK_LINES - 1) ||
         $past(hs_bad_ff) >= RUN_W'(UNLOCK_LINES - 1)))
        else $error("lock dropped before fifteen differing lines");
    chk_result_hold: assert property (!lk && !ln_end |=> // [RQ22]
        $stable(m.total) || $past(m.restart))
        else $error("line period changed while unlocked");
endmodule // hhtm_line_meas
`default_nettype wire

// *** hhtm_meas_if.sv ***
// interface: pixel samples in, line measurements out
`timescale 1ns/1ps
`default_nettype none
interface hhtm_meas_if;
    import hhtm_pkg::*;
    logic             tick;     // one pixel has passed
    logic             de;       // sampled data enable
    logic             hs;       // sampled horizontal sync
    logic             restart;  // port changed, start over
    logic [TOT_W-1:0] total;    // pixels per line
    logic [ACT_W-1:0] active;   // active pixels
    logic [ACT_W-1:0] fporch;   // front porch
    logic [ACT_W-1:0] pulse;    // sync pulse
    logic [ACT_W-1:0] bporch;   // back porch
    logic             pol;      // 1: sync active high
    logic             locked;   // filter locked
    logic             line_end; // one-cycle, at each line end
    modport meas (input tick, de, hs, restart, output total, active,
                  fporch, pulse, bporch, pol, locked, line_end);
    modport ctrl (output tick, de, hs, restart, input total, active,
                  fporch, pulse, bporch, pol, locked, line_end);
endinterface
`default_nettype wire

// *** hhtm_pkg.sv ***
// package: offsets, field positions and counts of the line timing measure
package hhtm_pkg;
    localparam int NPORT        = 8;    // selectable input ports
    localparam int PSEL_W       = 3;    // port selection width
    localparam int TOT_W        = 14;   // line period field width
    localparam int ACT_W        = 13;   // other width fields
    localparam int CNT_W        = 14;   // pixel position counter
    localparam int RUN_W        = 4;    // line run counters
    localparam int LOCK_LINES   = 8;    // matching lines to lock
    localparam int UNLOCK_LINES = 15;   // differing lines to unlock
    // byte offsets, main map
    localparam logic [7:0] OFS_POL     = 8'h05;
    localparam logic [7:0] OFS_ACT_HI  = 8'h07;
    localparam logic [7:0] OFS_ACT_LO  = 8'h08;
    localparam logic [7:0] OFS_TOT_HI  = 8'h1E;
    localparam logic [7:0] OFS_TOT_LO  = 8'h1F;
    localparam logic [7:0] OFS_FP_HI   = 8'h20;
    localparam logic [7:0] OFS_FP_LO   = 8'h21;
    localparam logic [7:0] OFS_PW_HI   = 8'h22;
    localparam logic [7:0] OFS_PW_LO   = 8'h23;
    localparam logic [7:0] OFS_BP_HI   = 8'h24;
    localparam logic [7:0] OFS_BP_LO   = 8'h25;
    localparam logic [7:0] OFS_BACT_HI = 8'hE2;
    localparam logic [7:0] OFS_BACT_LO = 8'hE3;
    localparam logic [7:0] OFS_BTOT_HI = 8'hE4;
    localparam logic [7:0] OFS_BTOT_LO = 8'hE5;
    localparam logic [7:0] OFS_BLOCK   = 8'hEA;
    // byte offset, io map
    localparam logic [7:0] OFS_RAW     = 8'h6A;
    // bit positions
    localparam int POL_BIT   = 5;
    localparam int LOCK_BIT  = 5;
    localparam int RAW_BIT   = 0;
    localparam int BLOCK_BIT = 1;
    // reset value of the line period fields
    localparam logic [TOT_W-1:0] MEAS_RST = 14'h0000;
    // colour depth of the incoming stream
    typedef enum logic [1:0] {DC_24, DC_30, DC_36, DC_48} hhtm_dc_t;
endpackage

// *** hhtm_src_model.sv ***
// model of the video source: character clock, DE and sync per port
`timescale 1ns/1ps
`default_nettype none
module hhtm_src_model #(
    parameter int TOT = 40,  // characters per line
    parameter int SW  = 5,   // sync pulse characters
    parameter int BP  = 5,   // back porch characters
    parameter int ACT = 25   // active characters on port 0
) (
    output logic       pclk,   // free running character clock
    output logic [7:0] de_o,   // DE per port
    output logic [7:0] hs_o,   // sync per port, active high
    input  wire logic  jitter  // 1: DE rise moves on odd lines
);
    int   pos;
    logic odd;
    // lines change after the rising edge, steady over the falling one
    initial begin
        pclk = 1'b0;
        pos = 0;
        odd = 1'b0;
        de_o = 8'h00;
        hs_o = 8'h00;
        forever begin
            #400 pclk = ~pclk;
            if (pclk) begin
                pos = (pos == TOT - 1) ? 0 : pos + 1;
                if (pos == 0)
                    odd = ~odd;
                // port p carries p fewer active characters
                for (int p = 0; p < 8; p++) begin
                    hs_o[p] = (pos < SW);
                    de_o[p] = (pos >= SW + BP + int'(jitter && odd))
                              && (pos < SW + BP + ACT - p);
                end
            end
        end
    end
endmodule // hhtm_src_model
`default_nettype wire

// *** hhtm_timing_top.sv ***
// horizontal timing measure of primary and secondary video ports
// Summary of operation
// (RQ1) lock after DE and sync transitions match on eight lines in a row; good_ff sticks at 15 until restart, then one match locks
// (RQ2) unlock after DE or sync transitions differ on fifteen lines in row; de_bad_ff and hs_bad_ff stick at 15 until restart, then one miss unlocks
// (RQ3) lock flag at 0x07 bit 5 shows filter lock
// (RQ4) live lock status at io map 0x6A bit 0
// (RQ5) 14-bit line period at 0x1E bits 5:0 and 0x1F
// (RQ6) 13-bit active width at 0x07 bits 4:0 and 0x08
// (RQ7) 13-bit front porch at 0x20 bits 4:0 and 0x21
// (RQ8) 13-bit sync pulse at 0x22 bits 4:0 and 0x23
// (RQ9) 13-bit back porch at 0x24 bits 4:0 and 0x25
// (RQ10) software trusts primary widths only while locked
// (RQ11) sync sense at 0x05 bit 5, 1 means active high
// (RQ12) secondary measure runs on its own three-bit port choice
// (RQ13) secondary widths refresh only on request, hold otherwise
// (RQ14) secondary lock flag at 0xEA bit 1, lock at capture time
// (RQ15) secondary 14-bit line period at 0xE4 bits 5:0 and 0xE5
// (RQ16) secondary 13-bit active width at 0xE2 bits 4:0 and 0xE3
// (RQ17) software trusts secondary widths only with secondary lock set
// (RQ18) primary measure uses DE and sync of the primary port
// (RQ19) counts are picture pixels, after colour depth and repetition
// (RQ20) measure only taps the stream, adds no latency to video
// (RQ21) high and low bytes of one value come from one snapshot
// (RQ22) flags and measurements read zero after reset until lock; sync sense at 0x05 updates at every line end
`timescale 1ns/1ps
`default_nettype none
module hhtm_timing_top (
    input  wire logic                     clk,        // 10 MHz clock
    input  wire logic                     rst,        // async, high
    input  wire logic                     pclk_in,    // link char clock
    input  wire logic [hhtm_pkg::NPORT-1:0] de_in,    // port DE
    input  wire logic [hhtm_pkg::NPORT-1:0] hs_in,    // port sync
    input  wire logic [hhtm_pkg::PSEL_W-1:0] primary_port_choice, // port
    input  wire logic [hhtm_pkg::PSEL_W-1:0] secondary_port_choice, // bg port
    input  wire logic                     secondary_measure_request, // bg arm
    input  wire hhtm_pkg::hhtm_dc_t       dc_mode,    // colour depth
    input  wire logic [3:0]               pix_rep,    // repetitions
    input  wire logic                     rd_en,      // read strobe
    input  wire logic                     rd_io,      // 1: io map
    input  wire logic [7:0]               rd_addr,    // byte offset
    output logic [7:0]                    rd_data,    // read byte
    output logic                          horiz_lock  // primary lock
);
    import hhtm_pkg::*;
    hhtm_meas_if p_if ();
    hhtm_meas_if b_if ();
    logic              pclk_s1_ff, pclk_s2_ff, pclk_s3_ff, char_fall;
    logic [NPORT-1:0]  de_s1_ff, de_s2_ff, hs_s1_ff, hs_s2_ff;
    logic [NPORT-1:0]  de_smp_ff, hs_smp_ff;
    logic [2:0]        dc_acc_ff, dc_p, dc_q;
    logic [3:0]        dc_sum, rep_ff;
    logic              dc_tick_ff, tick_ff;
    logic [PSEL_W-1:0] psel_ff, bsel_ff;
    logic              prst_ff, brst_ff;
    logic              req_q_ff, bg_pend_ff, bg_lock_ff, lk_flag_ff;
    logic [TOT_W-1:0]  bg_tot_ff;
    logic [ACT_W-1:0]  bg_act_ff;
    logic [7:0]        rd_data_ff, hold_lo_ff, nxt_rd, nxt_hold;
    logic              horiz_lock_ff;
    // link clock through three flip-flops, DE and sync through two
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pclk_s1_ff <= 1'b0;
            pclk_s2_ff <= 1'b0;
            pclk_s3_ff <= 1'b0;
            de_s1_ff   <= '0;
            de_s2_ff   <= '0;
            hs_s1_ff   <= '0;
            hs_s2_ff   <= '0;
        end else begin
            pclk_s1_ff <= pclk_in;
            pclk_s2_ff <= pclk_s1_ff;
            pclk_s3_ff <= pclk_s2_ff;
            de_s1_ff   <= de_in;
            de_s2_ff   <= de_s1_ff;
            hs_s1_ff   <= hs_in;
            hs_s2_ff   <= hs_s1_ff;
        end
    end
    // falling link edge: mid-character, data settled
    assign char_fall = pclk_s3_ff & ~pclk_s2_ff;
    // sample every port once per character
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            de_smp_ff <= '0;
            hs_smp_ff <= '0;
        end else if (char_fall) begin
            de_smp_ff <= de_s2_ff;
            hs_smp_ff <= hs_s2_ff;
        end
    end
    // pixels per character ratio of each colour depth
    always_comb begin
        case (dc_mode)
            DC_24: begin
                dc_p = 3'h1;
                dc_q = 3'h1;
            end
            DC_30: begin
                dc_p = 3'h4;
                dc_q = 3'h5;
            end
            DC_36: begin
                dc_p = 3'h2;
                dc_q = 3'h3;
            end
            DC_48: begin
                dc_p = 3'h1;
                dc_q = 3'h2;
            end
            default: begin
                dc_p = 3'h1;
                dc_q = 3'h1;
            end
        endcase
    end
    assign dc_sum = {1'b0, dc_acc_ff} + {1'b0, dc_p};
    // colour depth accumulator: p pixels every q characters
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dc_acc_ff  <= 3'h0;
            dc_tick_ff <= 1'b0;
        end else if (char_fall && dc_sum >= {1'b0, dc_q}) begin
            dc_acc_ff  <= 3'(dc_sum - {1'b0, dc_q});
            dc_tick_ff <= 1'b1;                                     // [RQ19]
        end else begin
            if (char_fall) dc_acc_ff <= dc_sum[2:0];
            dc_tick_ff <= 1'b0;
        end
    end
    // pixel repetition: one picture pixel per pix_rep+1 pixels
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rep_ff  <= 4'h0;
            tick_ff <= 1'b0;
        end else if (dc_tick_ff && rep_ff >= pix_rep) begin
            rep_ff  <= 4'h0;
            tick_ff <= 1'b1;                                        // [RQ19]
        end else begin
            if (dc_tick_ff) rep_ff <= rep_ff + 4'h1;
            tick_ff <= 1'b0;
        end
    end
    // port choices, a change restarts that measure
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            psel_ff <= '0;
            bsel_ff <= '0;
            prst_ff <= 1'b1;
            brst_ff <= 1'b1;
        end else begin
            psel_ff <= primary_port_choice;
            bsel_ff <= secondary_port_choice;
            prst_ff <= (primary_port_choice != psel_ff);
            brst_ff <= (secondary_port_choice != bsel_ff);
        end
    end
    // taps only copies of the stream, video path untouched      [RQ20]
    assign p_if.tick    = tick_ff;
    assign p_if.de      = de_smp_ff[psel_ff];                      // [RQ18]
    assign p_if.hs      = hs_smp_ff[psel_ff];                      // [RQ18]
    assign p_if.restart = prst_ff;
    assign b_if.tick    = tick_ff;
    assign b_if.de      = de_smp_ff[bsel_ff];                      // [RQ12]
    assign b_if.hs      = hs_smp_ff[bsel_ff];                      // [RQ12]
    assign b_if.restart = brst_ff;
    hhtm_line_meas u_prim (
        .clk (clk),
        .rst (rst),
        .m   (p_if.meas)
    );
    hhtm_line_meas u_bkgd (
        .clk (clk),
        .rst (rst),
        .m   (b_if.meas)
    );
    // lock flag follows the results it qualifies
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lk_flag_ff    <= 1'b0;                                  // [RQ22]
            horiz_lock_ff <= 1'b0;
        end else begin
            horiz_lock_ff <= p_if.locked;
            if (!p_if.locked) lk_flag_ff <= 1'b0;
            else if (p_if.line_end) lk_flag_ff <= 1'b1;             // [RQ3]
        end
    end
    // secondary capture on request, held in between
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_q_ff   <= 1'b0;
            bg_pend_ff <= 1'b0;
            bg_lock_ff <= 1'b0;
            bg_tot_ff  <= MEAS_RST;
            bg_act_ff  <= '0;
        end else begin
            req_q_ff <= secondary_measure_request;
            if (secondary_measure_request && !req_q_ff)
                bg_pend_ff <= 1'b1;
            else if (bg_pend_ff && b_if.line_end) begin
                bg_pend_ff <= 1'b0;
                bg_tot_ff  <= b_if.total;                           // [RQ13]
                bg_act_ff  <= b_if.active;                          // [RQ13]
                bg_lock_ff <= b_if.locked;                          // [RQ14]
            end
        end
    end
    // read decode, low byte from the snapshot of the high read
    always_comb begin
        nxt_rd   = 8'h00;
        nxt_hold = hold_lo_ff;
        if (rd_io) begin
            if (rd_addr == OFS_RAW) nxt_rd[RAW_BIT] = p_if.locked;  // [RQ4]
        end else begin
            case (rd_addr)
                OFS_POL: nxt_rd[POL_BIT] = p_if.pol;                // [RQ11]
                OFS_ACT_HI: begin
                    nxt_rd[LOCK_BIT] = lk_flag_ff;                  // [RQ3]
                    nxt_rd[4:0] = p_if.active[ACT_W-1:8];           // [RQ6]
                    nxt_hold = p_if.active[7:0];                    // [RQ21]
                end
                OFS_TOT_HI: begin
                    nxt_rd[5:0] = p_if.total[TOT_W-1:8];            // [RQ5]
                    nxt_hold = p_if.total[7:0];                     // [RQ21]
                end
                OFS_FP_HI: begin
                    nxt_rd[4:0] = p_if.fporch[ACT_W-1:8];           // [RQ7]
                    nxt_hold = p_if.fporch[7:0];
                end
                OFS_PW_HI: begin
                    nxt_rd[4:0] = p_if.pulse[ACT_W-1:8];            // [RQ8]
                    nxt_hold = p_if.pulse[7:0];
                end
                OFS_BP_HI: begin
                    nxt_rd[4:0] = p_if.bporch[ACT_W-1:8];           // [RQ9]
                    nxt_hold = p_if.bporch[7:0];
                end
                OFS_BACT_HI: begin
                    nxt_rd[4:0] = bg_act_ff[ACT_W-1:8];             // [RQ16]
                    nxt_hold = bg_act_ff[7:0];
                end
                OFS_BTOT_HI: begin
                    nxt_rd[5:0] = bg_tot_ff[TOT_W-1:8];             // [RQ15]
                    nxt_hold = bg_tot_ff[7:0];
                end
                OFS_ACT_LO, OFS_TOT_LO, OFS_FP_LO, OFS_PW_LO, OFS_BP_LO,
                OFS_BACT_LO, OFS_BTOT_LO: nxt_rd = hold_lo_ff;      // [RQ21]
                OFS_BLOCK: nxt_rd[BLOCK_BIT] = bg_lock_ff;          // [RQ14]
                default: nxt_rd = 8'h00;
            endcase
        end
    end
    // read data register, updated on each strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data_ff <= 8'h00;
            hold_lo_ff <= 8'h00;
        end else if (rd_en) begin
            rd_data_ff <= nxt_rd;
            hold_lo_ff <= nxt_hold;
        end
    end
    assign rd_data    = rd_data_ff;
    assign horiz_lock = horiz_lock_ff;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_tot_hi;
        rd_en && !rd_io && rd_addr == OFS_TOT_HI;
    endsequence
    sequence s_tot_lo;
        rd_en && !rd_io && rd_addr == OFS_TOT_LO;
    endsequence
    sequence s_req;
        secondary_measure_request && !req_q_ff;
    endsequence
    chk_raw_read: assert property (rd_en && rd_io && // [RQ4]
        rd_addr == OFS_RAW |=> rd_data[RAW_BIT] == $past(p_if.locked))
        else $error("raw lock read wrong");
    chk_pair_snapshot: assert property (s_tot_hi ##1 s_tot_lo |=> // [RQ21]
        rd_data == $past(p_if.total[7:0], 2))
        else $error("low byte not from high byte snapshot");
    chk_bg_hold: assert property (!(bg_pend_ff && b_if.line_end) |=> // [RQ13]
        $stable(bg_tot_ff) && $stable(bg_lock_ff))
        else $error("secondary result changed without request");
    chk_bg_arm: assert property (s_req |=> bg_pend_ff) // [RQ13]
        else $error("secondary request not armed");
    chk_bg_capture: assert property (bg_pend_ff && b_if.line_end && // [RQ13]
        !(secondary_measure_request && !req_q_ff) |=>
        bg_tot_ff == $past(b_if.total) &&
        bg_lock_ff == $past(b_if.locked) && !bg_pend_ff)
        else $error("secondary capture missed");
    chk_tot_high: assert property (s_tot_hi |=> // [RQ5]
        rd_data == {2'b00, $past(p_if.total[TOT_W-1:8])})
        else $error("line period high byte wrong");
    chk_flag_set: assert property (p_if.locked && p_if.line_end |=> // [RQ3]
        lk_flag_ff)
        else $error("lock flag not set at locked line end");
    chk_rd_hold: assert property (!rd_en |=> $stable(rd_data)) // [RQ21]
        else $error("read data changed without strobe");
    chk_tick_source: assert property (tick_ff |-> // [RQ19]
        $past(dc_tick_ff) && rep_ff == 4'h0)
        else $error("pixel tick without colour depth tick");
    chk_flag_clear: assert property (!p_if.locked |=> !lk_flag_ff) // [RQ3]
        else $error("lock flag set while unlocked");
endmodule // hhtm_timing_top
`default_nettype wire

// *** test_hhtm_timing_top.sv ***
// testbench: register readbacks of the line timing measure
`timescale 1ns/1ps
`default_nettype none
module test_hhtm_timing_top;
    import hhtm_pkg::*;
    logic        clk, rst, pclk, jit, req, rd_en, rd_io, lock;
    logic [7:0]  de, hs, rd_addr, rd_data;
    logic [2:0]  sec_sel, psel;
    logic [3:0]  rep;
    hhtm_dc_t    dc;
    logic [15:0] v;
    int          fails = 0;
    int          compares = 0;
    logic [7:0]  ofs [10] = '{OFS_POL, OFS_ACT_HI, OFS_TOT_HI, OFS_FP_HI,
        OFS_PW_HI, OFS_BP_HI, OFS_BACT_HI, OFS_BTOT_HI, OFS_BLOCK, 8'h40};
    logic [15:0] lck [10] = '{16'h2000, 16'h2019, 16'h0028, 16'h0005,
        16'h0005, 16'h0005, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    hhtm_src_model src (.pclk(pclk), .de_o(de), .hs_o(hs), .jitter(jit));
    hhtm_timing_top dut (.clk(clk), .rst(rst), .pclk_in(pclk),
        .de_in(de), .hs_in(hs), .primary_port_choice(psel),
        .secondary_port_choice(sec_sel), .secondary_measure_request(req),
        .dc_mode(dc), .pix_rep(rep), .rd_en(rd_en), .rd_io(rd_io),
        .rd_addr(rd_addr), .rd_data(rd_data), .horiz_lock(lock));
    // compare and count
    task automatic chk(input string n, input logic [15:0] got, exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
        end
    endtask
    // read one byte, or a high byte followed by its low byte
    task automatic rd(input logic io, input logic [7:0] a, input logic two,
                      output logic [15:0] d);
        @(negedge clk);
        rd_en = 1'b1;
        rd_io = io;
        rd_addr = a;
        @(negedge clk);
        d = {8'h00, rd_data};
        rd_addr = a + 8'h01;
        rd_en = two;
        @(negedge clk);
        rd_en = 1'b0;
        if (two)
            d = {d[7:0], rd_data};
    endtask
    // one line is 40 characters of 8 clocks
    task automatic lines(input int n);
        repeat (n * 320) @(negedge clk);
    endtask
    task automatic stop_test();
        $display("counts: compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // watchdog well beyond the expected 2 ms
    initial begin
        #4_000_000;
        fails++;
        stop_test();
    end
    initial begin
        rst = 1'b1;
        jit = 1'b0;
        req = 1'b0;
        rd_en = 1'b0;
        rd_io = 1'b0;
        rd_addr = 8'h00;
        sec_sel = 3'h5;
        psel = 3'h0;
        rep = 4'h0;
        dc = DC_24;
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        foreach (ofs[i]) begin
            rd(1'b0, ofs[i], 1'b1, v);
            chk("reset value", v, 16'h0000);
        end
        $display("test reset done");
        lines(6);
        chk("early lock", {15'h0000, lock}, 16'h0000);
        lines(8);
        chk("lock", {15'h0000, lock}, 16'h0001);
        foreach (ofs[i]) begin
            rd(1'b0, ofs[i], 1'b1, v);
            chk("locked value", v, lck[i]);
        end
        rd(1'b1, OFS_RAW, 1'b0, v);
        chk("live lock", v, 16'h0001);
        $display("test lock done");
        req = 1'b1;
        lines(3);
        req = 1'b0;
        rd(1'b0, OFS_BACT_HI, 1'b1, v);
        chk("bg active", v, 16'h0014);
        rd(1'b0, OFS_BTOT_HI, 1'b1, v);
        chk("bg total", v, 16'h0028);
        rd(1'b0, OFS_BLOCK, 1'b1, v);
        chk("bg lock", v, 16'h0200);
        $display("test background done");
        jit = 1'b1;
        lines(12);
        chk("lock held", {15'h0000, lock}, 16'h0001);
        lines(6);
        chk("unlock", {15'h0000, lock}, 16'h0000);
        rd(1'b0, OFS_ACT_HI, 1'b0, v);
        chk("lock flag", v & 16'h0020, 16'h0000);
        rd(1'b1, OFS_RAW, 1'b0, v);
        chk("live unlock", v, 16'h0000);
        $display("test unlock done");
        jit = 1'b0;
        dc = DC_30;
        psel = 3'h5;
        lines(14);
        rd(1'b0, OFS_TOT_HI, 1'b1, v);
        chk("total 30 bit", v, 16'h0020);
        rd(1'b0, OFS_ACT_HI, 1'b1, v);
        chk("active port 5", v, 16'h2010);
        rd(1'b0, OFS_BTOT_HI, 1'b1, v);
        chk("bg total held", v, 16'h0028);
        $display("test colour depth done");
        dc = DC_48;
        lines(6);
        rd(1'b0, OFS_TOT_HI, 1'b1, v);
        chk("total 48 bit", v, 16'h0014);
        dc = DC_24;
        rep = 4'h3;
        lines(6);
        rd(1'b0, OFS_TOT_HI, 1'b1, v);
        chk("total repeat", v, 16'h000A);
        $display("test repetition done");
        stop_test();
    end
endmodule // test_hhtm_timing_top
`default_nettype wire
